// ### verilog/cap_neg_pkg.sv
package cap_neg_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] status_off = 8'h04;
    localparam logic [7:0] phy_policy_off = 8'h08;
    localparam logic [7:0] oth_policy_off = 8'h0c;
    localparam logic [7:0] phy_result_off = 8'h10;
    localparam logic [7:0] oth_result_lo_off = 8'h14;
    localparam logic [7:0] oth_result_hi_off = 8'h18;
    localparam int ctrl_start_bit = 0;
    localparam int ctrl_skip_phy_bit = 1;
    localparam int ctrl_skip_oth_bit = 2;
    localparam int st_bad_rep_bit = 4;
    localparam int st_unexp_bit = 5;
    localparam int st_done_bit = 6;
    localparam int st_phy_valid_bit = 7;
    localparam logic [31:0] phy_policy_rst = 32'h0000_0fff;
    localparam logic [31:0] oth_policy_rst = 32'hffff_ffff;
    localparam logic [31:0] unmapped_data = 32'h0000_0000;

    // ==========================================================
    // Message types on the control path
    localparam logic [2:0] msg_none = 3'h0;
    localparam logic [2:0] msg_phy_req = 3'h1;
    localparam logic [2:0] msg_phy_info = 3'h2;
    localparam logic [2:0] msg_phy_cnf = 3'h3;
    localparam logic [2:0] msg_oth_req = 3'h4;
    localparam logic [2:0] msg_oth_info = 3'h5;
    localparam logic [2:0] msg_oth_cnf = 3'h6;

    // ==========================================================
    // Physical report and confirmation fields
    localparam int pi_dl64 = 0;
    localparam int pi_ul16 = 1;
    localparam int pi_turbo = 2;
    localparam int pi_pwr_qpsk = 3;
    localparam int pi_pwr_16 = 7;
    localparam int pi_nsaid = 11;
    localparam int pi_term = 21;
    localparam int pc_dl64 = 0;
    localparam int pc_ul16 = 1;
    localparam int pc_turbo = 2;
    localparam int pc_preamble = 3;
    localparam int pc_pwr_qpsk = 4;
    localparam int pc_pwr_16 = 8;
    localparam int pc_init = 12;
    localparam int pwr_w = 4;
    localparam int nsaid_w = 10;
    localparam logic [9:0] nsaid_min = 10'h001;
    localparam logic init_continue = 1'b0;
    localparam logic init_finished = 1'b1;

    // ==========================================================
    // Other report and confirmation fields
    localparam int oi_sa = 32;
    localparam int oi_cr = 42;
    localparam int oi_tdes = 43;
    localparam int oc_tdes = 32;
    localparam int oc_init = 33;
    localparam int sa_w = 10;

    typedef enum logic [3:0] {
        st_idle = 4'b0000,
        st_phy_req = 4'b0001,
        st_phy_wait = 4'b0010,
        st_phy_cnf = 4'b0011,
        st_auth = 4'b0100,
        st_oth_req = 4'b0101,
        st_oth_wait = 4'b0110,
        st_oth_cnf = 4'b0111,
        st_done = 4'b1000
    } neg_state_type;
endpackage : cap_neg_pkg

// ### verilog/use_limit.sv
`timescale 1ns/100ps
module use_limit #(
    parameter int W = 8
) (
    input wire logic [W-1:0] wanted,
    input wire logic [W-1:0] supported,
    output logic [W-1:0] granted
);
    assign granted = (wanted < supported) ? wanted : supported;
endmodule : use_limit

// ### verilog/report_check.sv
`timescale 1ns/100ps
module report_check (
    input wire logic is_phy,
    input wire logic long_pdu,
    input wire logic [9:0] nsaid,
    output logic ok
);
    // A turbo coded or long report cannot be trusted before turbo use is settled.
    assign ok = is_phy ? (!long_pdu && nsaid >= cap_neg_pkg::nsaid_min) : 1'b1;
endmodule : report_check

// ### verilog/cap_neg_engine.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Order is physical step, authentication, other step.
// - Physical exchange is request, report, confirmation.
// - Access point may skip physical step on reinit.
// - Three support flags, matching use flags.
// - Two 4-bit power limits in report and confirmation.
// - Confirmation preamble bit: 0 is 16, 1 is 32.
// - Status bit 0 continue, 1 finished.
// - Grant only short units during physical report.
// - Decode report assuming no turbo coding.
// - Other exchange is request, report, confirmation.
// - Four counts reported, four used counts returned.
// - Reported security association count bounds identifiers; the engine only stores it in the other result.
// - Contention resolution reported, never confirmed.
// - Triple-DES support flag and use flag.
module cap_neg_engine #(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [2:0] tx_type,
    output logic [63:0] tx_data,
    input wire logic rx_valid,
    input wire logic [2:0] rx_type,
    input wire logic rx_long_pdu,
    input wire logic [63:0] rx_data,
    output logic short_grants_only,
    output logic decode_no_turbo,
    output logic auth_req,
    input wire logic auth_done,
    output logic init_done
);
    // ==========================================================
    // Register file
    logic skip_phy_q, skip_oth_q, bad_rep_q, unexp_q, phy_valid_q;
    logic [31:0] phy_policy_q, oth_policy_q, phy_result_q;
    logic [43:0] oth_result_q;
    logic [31:0] prdata_q, rd_d;
    logic setup, wr, start, hit, bad_rep_ev, unexp_ev, info_ok;
    cap_neg_pkg::neg_state_type state_q, state_d;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign pready = psel && penable;
    assign hit = paddr <= cap_neg_pkg::oth_result_hi_off && paddr[1:0] == 2'b00;
    assign pslverr = pready && !hit;
    assign prdata = prdata_q;
    assign start = wr && paddr == cap_neg_pkg::ctrl_off && pwdata[cap_neg_pkg::ctrl_start_bit];

    always_comb begin
        case (paddr)
            cap_neg_pkg::ctrl_off: rd_d = {29'h0, skip_oth_q, skip_phy_q, 1'b0};
            cap_neg_pkg::status_off: rd_d = {24'h0, phy_valid_q, init_done, unexp_q, bad_rep_q,
                                             state_q};
            cap_neg_pkg::phy_policy_off: rd_d = phy_policy_q;
            cap_neg_pkg::oth_policy_off: rd_d = oth_policy_q;
            cap_neg_pkg::phy_result_off: rd_d = phy_result_q;
            cap_neg_pkg::oth_result_lo_off: rd_d = oth_result_q[31:0];
            cap_neg_pkg::oth_result_hi_off: rd_d = {20'h0, oth_result_q[43:32]};
            default: rd_d = cap_neg_pkg::unmapped_data;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_phy_q <= 1'b0;
            skip_oth_q <= 1'b0;
            phy_policy_q <= cap_neg_pkg::phy_policy_rst;
            oth_policy_q <= cap_neg_pkg::oth_policy_rst;
        end else if (wr) begin
            if (paddr == cap_neg_pkg::ctrl_off) begin
                skip_phy_q <= pwdata[cap_neg_pkg::ctrl_skip_phy_bit];
                skip_oth_q <= pwdata[cap_neg_pkg::ctrl_skip_oth_bit];
            end
            if (paddr == cap_neg_pkg::phy_policy_off) begin
                phy_policy_q <= pwdata;
            end
            if (paddr == cap_neg_pkg::oth_policy_off) begin
                oth_policy_q <= pwdata;
            end
        end
    end

    // Sticky error flags; a new event in the clearing cycle keeps the flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_rep_q <= 1'b0;
            unexp_q <= 1'b0;
        end else begin
            bad_rep_q <= bad_rep_ev || (bad_rep_q && !(wr && paddr == cap_neg_pkg::status_off
                         && pwdata[cap_neg_pkg::st_bad_rep_bit]));
            unexp_q <= unexp_ev || (unexp_q && !(wr && paddr == cap_neg_pkg::status_off
                       && pwdata[cap_neg_pkg::st_unexp_bit]));
        end
    end

    // ==========================================================
    // Negotiation sequencer
    logic want_phy, want_oth;
    assign want_phy = rx_valid && rx_type == cap_neg_pkg::msg_phy_info;
    assign want_oth = rx_valid && rx_type == cap_neg_pkg::msg_oth_info;

    report_check u_check (
        .is_phy(state_q == cap_neg_pkg::st_phy_wait),
        .long_pdu(rx_long_pdu),
        .nsaid(rx_data[cap_neg_pkg::pi_nsaid +: cap_neg_pkg::nsaid_w]),
        .ok(info_ok)
    );

    assign bad_rep_ev = state_q == cap_neg_pkg::st_phy_wait && want_phy && !info_ok;
    assign unexp_ev = rx_valid && !(state_q == cap_neg_pkg::st_phy_wait && want_phy)
                      && !(state_q == cap_neg_pkg::st_oth_wait && want_oth);

    always_comb begin
        state_d = state_q;
        case (state_q)
            cap_neg_pkg::st_idle, cap_neg_pkg::st_done: begin
                // Skipping needs an earlier report, or the policy would clamp nothing.
                if (start) begin
                    // The skip bit written with start decides, not the stored copy.
                    state_d = (pwdata[cap_neg_pkg::ctrl_skip_phy_bit] && phy_valid_q)
                              ? cap_neg_pkg::st_auth
                              : cap_neg_pkg::st_phy_req;
                end
            end
            cap_neg_pkg::st_phy_req: begin
                if (tx_ready) begin
                    state_d = cap_neg_pkg::st_phy_wait;
                end
            end
            cap_neg_pkg::st_phy_wait: begin
                if (want_phy && info_ok) begin
                    state_d = cap_neg_pkg::st_phy_cnf;
                end
            end
            cap_neg_pkg::st_phy_cnf: begin
                if (tx_ready) begin
                    state_d = cap_neg_pkg::st_auth;
                end
            end
            cap_neg_pkg::st_auth: begin
                if (auth_done) begin
                    state_d = skip_oth_q ? cap_neg_pkg::st_done : cap_neg_pkg::st_oth_req;
                end
            end
            cap_neg_pkg::st_oth_req: begin
                if (tx_ready) begin
                    state_d = cap_neg_pkg::st_oth_wait;
                end
            end
            cap_neg_pkg::st_oth_wait: begin
                if (want_oth) begin
                    state_d = cap_neg_pkg::st_oth_cnf;
                end
            end
            cap_neg_pkg::st_oth_cnf: begin
                if (tx_ready) begin
                    state_d = cap_neg_pkg::st_done;
                end
            end
            default: state_d = cap_neg_pkg::st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= cap_neg_pkg::st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    assign short_grants_only = state_q == cap_neg_pkg::st_phy_wait;
    assign decode_no_turbo = state_q == cap_neg_pkg::st_phy_wait;
    assign auth_req = state_q == cap_neg_pkg::st_auth;
    assign init_done = state_q == cap_neg_pkg::st_done;

    // ==========================================================
    // Reports and confirmations
    logic [3:0] pwr_qpsk_use, pwr_16_use;
    logic [CNT_W-1:0] cnt_use [4];
    logic [63:0] tx_data_q;
    logic [2:0] tx_type_q;

    use_limit #(.W(cap_neg_pkg::pwr_w)) u_pwr_qpsk (
        .wanted(phy_policy_q[cap_neg_pkg::pc_pwr_qpsk +: cap_neg_pkg::pwr_w]),
        .supported(rx_data[cap_neg_pkg::pi_pwr_qpsk +: cap_neg_pkg::pwr_w]),
        .granted(pwr_qpsk_use)
    );
    use_limit #(.W(cap_neg_pkg::pwr_w)) u_pwr_16 (
        .wanted(phy_policy_q[cap_neg_pkg::pc_pwr_16 +: cap_neg_pkg::pwr_w]),
        .supported(rx_data[cap_neg_pkg::pi_pwr_16 +: cap_neg_pkg::pwr_w]),
        .granted(pwr_16_use)
    );

    for (genvar i = 0; i < 4; i++) begin : g_cnt
        use_limit #(.W(CNT_W)) u_cnt (
            .wanted(oth_policy_q[i*CNT_W +: CNT_W]),
            .supported(rx_data[i*CNT_W +: CNT_W]),
            .granted(cnt_use[i])
        );
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_result_q <= 32'h0;
            phy_valid_q <= 1'b0;
            oth_result_q <= 44'h0;
        end else begin
            if (state_q == cap_neg_pkg::st_phy_wait && want_phy && info_ok) begin
                phy_result_q <= {10'h0, rx_data[21:0]};
                phy_valid_q <= 1'b1;
            end
            if (state_q == cap_neg_pkg::st_oth_wait && want_oth) begin
                oth_result_q <= rx_data[43:0];
            end
        end
    end

    // The bit-wise and keeps every use flag within what was reported.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_q <= 64'h0;
            tx_type_q <= cap_neg_pkg::msg_none;
        end else if (state_d != state_q) begin
            // Fields are built once, on entry, so the offer stands while the peer waits.
            // Idle report data may change meanwhile, which is why nothing is rebuilt later.
            case (state_d)
                cap_neg_pkg::st_phy_req: begin
                    tx_type_q <= cap_neg_pkg::msg_phy_req;
                    tx_data_q <= 64'h0;
                end
                cap_neg_pkg::st_phy_cnf: begin
                    tx_type_q <= cap_neg_pkg::msg_phy_cnf;
                    tx_data_q <= 64'h0;
                    tx_data_q[cap_neg_pkg::pc_dl64] <= phy_policy_q[cap_neg_pkg::pc_dl64]
                        & rx_data[cap_neg_pkg::pi_dl64];
                    tx_data_q[cap_neg_pkg::pc_ul16] <= phy_policy_q[cap_neg_pkg::pc_ul16]
                        & rx_data[cap_neg_pkg::pi_ul16];
                    tx_data_q[cap_neg_pkg::pc_turbo] <= phy_policy_q[cap_neg_pkg::pc_turbo]
                        & rx_data[cap_neg_pkg::pi_turbo];
                    tx_data_q[cap_neg_pkg::pc_preamble] <= phy_policy_q[cap_neg_pkg::pc_preamble];
                    tx_data_q[cap_neg_pkg::pc_pwr_qpsk +: cap_neg_pkg::pwr_w] <= pwr_qpsk_use;
                    tx_data_q[cap_neg_pkg::pc_pwr_16 +: cap_neg_pkg::pwr_w] <= pwr_16_use;
                    tx_data_q[cap_neg_pkg::pc_init] <= cap_neg_pkg::init_continue;
                end
                cap_neg_pkg::st_oth_req: begin
                    tx_type_q <= cap_neg_pkg::msg_oth_req;
                    tx_data_q <= 64'h0;
                end
                cap_neg_pkg::st_oth_cnf: begin
                    tx_type_q <= cap_neg_pkg::msg_oth_cnf;
                    tx_data_q <= 64'h0;
                    tx_data_q[4*CNT_W-1:0] <= {cnt_use[3], cnt_use[2], cnt_use[1], cnt_use[0]};
                    tx_data_q[cap_neg_pkg::oc_tdes] <= oth_policy_q[cap_neg_pkg::oc_tdes - 1]
                        & rx_data[cap_neg_pkg::oi_tdes];
                    tx_data_q[cap_neg_pkg::oc_init] <= cap_neg_pkg::init_finished;
                end
                default: tx_type_q <= cap_neg_pkg::msg_none;
            endcase
        end
    end

    assign tx_type = tx_type_q;
    assign tx_data = tx_data_q;
    assign tx_valid = tx_type_q != cap_neg_pkg::msg_none;

    // ==========================================================
    // Checks
    sequence phy_info_taken;
        state_q == cap_neg_pkg::st_phy_wait && want_phy && info_ok;
    endsequence
    sequence cnf_sent;
        tx_valid && tx_ready && tx_type == cap_neg_pkg::msg_phy_cnf;
    endsequence
    sequence oth_info_taken;
        state_q == cap_neg_pkg::st_oth_wait && want_oth;
    endsequence

    order_auth_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnf_sent |=> state_q == cap_neg_pkg::st_auth)
        else $error("authentication does not follow the physical confirmation");
    phy_cnf_a: assert property (@(posedge pclk) disable iff (!presetn)
        phy_info_taken |=> tx_valid && tx_type == cap_neg_pkg::msg_phy_cnf)
        else $error("physical report not answered by confirmation");
    skip_phy_a: assert property (@(posedge pclk) disable iff (!presetn)
        start && (state_q == cap_neg_pkg::st_idle || init_done)
        && pwdata[cap_neg_pkg::ctrl_skip_phy_bit] && phy_valid_q |=> auth_req)
        else $error("physical step not skipped");
    flag_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid && tx_type == cap_neg_pkg::msg_phy_cnf |->
        !(tx_data[cap_neg_pkg::pc_turbo] && !phy_result_q[cap_neg_pkg::pi_turbo]))
        else $error("turbo use beyond support");
    pwr_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid && tx_type == cap_neg_pkg::msg_phy_cnf |->
        tx_data[cap_neg_pkg::pc_pwr_qpsk +: 4] <= phy_result_q[cap_neg_pkg::pi_pwr_qpsk +: 4])
        else $error("power limit beyond report");
    short_grant_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid && tx_ready && tx_type == cap_neg_pkg::msg_phy_req
        |=> short_grants_only && decode_no_turbo)
        else $error("long grants during physical report");
    nsaid_rej_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == cap_neg_pkg::st_phy_wait && want_phy
        && rx_data[cap_neg_pkg::pi_nsaid +: 10] == 10'h000 |=> !$rose(tx_valid) && bad_rep_q)
        else $error("zero identifier count accepted");
    finish_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid && tx_ready && tx_type == cap_neg_pkg::msg_oth_cnf
        |-> tx_data[cap_neg_pkg::oc_init] ##1 init_done)
        else $error("other confirmation does not finish");
    oth_cnf_a: assert property (@(posedge pclk) disable iff (!presetn)
        oth_info_taken |=> tx_valid && tx_type == cap_neg_pkg::msg_oth_cnf)
        else $error("other report not answered by confirmation");
    // A slow peer must see the same message on every cycle until it takes it.
    tx_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid && !tx_ready |=> $stable(tx_type) && $stable(tx_data))
        else $error("offered message changed before it was taken");
    long_rej_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == cap_neg_pkg::st_phy_wait && want_phy && rx_long_pdu
        |=> state_q == cap_neg_pkg::st_phy_wait && bad_rep_q)
        else $error("long physical report accepted");
    no_cr_cnf_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid && tx_type == cap_neg_pkg::msg_oth_cnf
        |-> tx_data[63:cap_neg_pkg::oc_init + 1] == 30'h0)
        else $error("other confirmation carries extra fields");
endmodule : cap_neg_engine

// ### test/term_model.sv
`timescale 1ns/100ps
// ==========================================================
// Terminal side of both capability exchanges.
module term_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [2:0] tx_type,
    input wire logic [63:0] tx_data,
    output logic rx_valid,
    output logic [2:0] rx_type,
    output logic rx_long_pdu,
    output logic [63:0] rx_data,
    input wire logic slow,
    input wire logic long_cfg,
    input wire logic kick,
    input wire logic [63:0] phy_rep,
    input wire logic [63:0] oth_rep,
    output logic [31:0] trace,
    output logic [63:0] phy_cnf,
    output logic [63:0] oth_cnf
);
    logic [1:0] wait_q;
    logic [1:0] dly_q;
    logic [2:0] pend_q;
    logic taken;
    assign taken = tx_valid && tx_ready;
    // A slow peer holds off ready, so the engine must keep its offer standing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            wait_q <= 2'h0;
        end else if (taken) begin
            tx_ready <= 1'b0;
            wait_q <= 2'h0;
        end else if (tx_valid) begin
            tx_ready <= !slow || wait_q == 2'h3;
            wait_q <= wait_q + 2'h1;
        end
    end
    // Idle data toggles so a stale report can never look valid.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_valid <= 1'b0;
            rx_type <= 3'h0;
            rx_long_pdu <= 1'b0;
            rx_data <= 64'h0;
            pend_q <= 3'h0;
            dly_q <= 2'h0;
            trace <= 32'h0;
            phy_cnf <= 64'h0;
            oth_cnf <= 64'h0;
        end else begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
            dly_q <= (pend_q != 3'h0) ? dly_q + 2'h1 : 2'h0;
            if (dly_q == 2'h3) begin
                rx_valid <= 1'b1;
                rx_type <= pend_q;
                rx_data <= (pend_q == cap_neg_pkg::msg_phy_info) ? phy_rep : oth_rep;
                rx_long_pdu <= long_cfg;
                pend_q <= 3'h0;
            end
            if (taken) begin
                trace <= {trace[28:0], tx_type};
                if (tx_type == cap_neg_pkg::msg_phy_req) pend_q <= cap_neg_pkg::msg_phy_info;
                if (tx_type == cap_neg_pkg::msg_oth_req) pend_q <= cap_neg_pkg::msg_oth_info;
                if (tx_type == cap_neg_pkg::msg_phy_cnf) phy_cnf <= tx_data;
                if (tx_type == cap_neg_pkg::msg_oth_cnf) oth_cnf <= tx_data;
            end
            if (kick) pend_q <= cap_neg_pkg::msg_phy_info;
        end
    end
endmodule : term_model

// ### test/capability_negotiation_engine_tb_top.sv
`timescale 1ns/100ps
module capability_negotiation_engine_tb_top;
    // ==========================================================
    // Engine, peer and shared state.
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic e;
    } row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, trace;
    logic tx_valid, tx_ready, rx_valid, rx_long_pdu, slow, long_cfg, kick;
    logic [2:0] tx_type, rx_type, flags;
    logic [63:0] tx_data, rx_data, phy_rep, oth_rep, phy_cnf, oth_cnf;
    logic short_grants_only, decode_no_turbo, auth_req, auth_done, init_done;
    int failures, n_compared;
    row_type rows [9] = '{'{cap_neg_pkg::ctrl_off, 32'h0, 1'b0},
        '{cap_neg_pkg::status_off, 32'h0, 1'b0},
        '{cap_neg_pkg::phy_policy_off, cap_neg_pkg::phy_policy_rst, 1'b0},
        '{cap_neg_pkg::oth_policy_off, cap_neg_pkg::oth_policy_rst, 1'b0},
        '{cap_neg_pkg::phy_result_off, 32'h0, 1'b0},
        '{cap_neg_pkg::oth_result_lo_off, 32'h0, 1'b0},
        '{cap_neg_pkg::oth_result_hi_off, 32'h0, 1'b0},
        '{8'h1c, cap_neg_pkg::unmapped_data, 1'b1},
        '{8'h02, cap_neg_pkg::unmapped_data, 1'b1}};
    assign flags = {short_grants_only, init_done, auth_req};
    cap_neg_engine #(.CNT_W(8)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tx_valid, .tx_ready, .tx_type, .tx_data,
        .rx_valid, .rx_type, .rx_long_pdu, .rx_data, .short_grants_only, .decode_no_turbo,
        .auth_req, .auth_done, .init_done);
    term_model peer_u (.pclk, .presetn, .tx_valid, .tx_ready, .tx_type, .tx_data,
        .rx_valid, .rx_type, .rx_long_pdu, .rx_data, .slow, .long_cfg, .kick, .phy_rep,
        .oth_rep, .trace, .phy_cnf, .oth_cnf);
    // ==========================================================
    // Bus, wait and compare tasks.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_hi(input int s);
        int n;
        n = 0;
        while (flags[s] !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk(64'(flags[s]), 64'h1);
    endtask : wait_hi
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, cap_neg_pkg::status_off, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 40);
        chk(64'(rd[b]), 64'h1);
    endtask : poll
    task automatic pulse(input logic k);
        if (k) kick <= 1'b1;
        else auth_done <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        auth_done <= 1'b0;
    endtask : pulse
    task automatic tally_and_finish;
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // ==========================================================
    // Stimulus.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {auth_done, slow, long_cfg, kick} = 4'h0;
        phy_rep = {42'h0, 1'b1, 10'h155, 4'h3, 4'h7, 3'b011};
        oth_rep = {20'h0, 2'b11, 10'h0aa, 8'h07, 8'h05, 8'h34, 8'h12};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk(64'(rd), 64'(rows[i].d));
            chk(64'(er), 64'(rows[i].e));
        end
        apb(1'b1, cap_neg_pkg::phy_policy_off, 32'h0000_0a5d);
        apb(1'b1, cap_neg_pkg::oth_policy_off, 32'h8410_2008);
        apb(1'b1, cap_neg_pkg::ctrl_off, 32'h1);
        wait_hi(2);
        chk(64'({short_grants_only, decode_no_turbo}), 64'h3);
        wait_hi(0);
        chk(phy_cnf, {51'h0, 1'b0, 4'h3, 4'h5, 1'b1, 3'b001});
        chk(64'(trace), {58'h0, 3'h1, 3'h3});
        pulse(1'b0);
        wait_hi(1);
        chk(oth_cnf, {30'h0, 2'b11, 8'h07, 8'h05, 8'h20, 8'h08});
        chk(64'(trace), {52'h0, 3'h1, 3'h3, 3'h4, 3'h6});
        apb(1'b0, cap_neg_pkg::phy_result_off, 32'h0);
        chk(64'(rd), 64'(phy_rep[21:0]));
        apb(1'b0, cap_neg_pkg::oth_result_lo_off, 32'h0);
        chk(64'(rd), 64'(oth_rep[31:0]));
        apb(1'b0, cap_neg_pkg::oth_result_hi_off, 32'h0);
        chk(64'(rd), 64'(oth_rep[43:32]));
        // Re-initialisation that skips the physical step, with a slow peer.
        slow <= 1'b1;
        apb(1'b1, cap_neg_pkg::ctrl_off, 32'h3);
        wait_hi(0);
        chk(64'(short_grants_only), 64'h0);
        pulse(1'b0);
        wait_hi(1);
        chk(64'(trace[11:0]), {52'h0, 3'h4, 3'h6, 3'h4, 3'h6});
        // Rejected reports, then a run that skips the other step.
        slow <= 1'b0;
        long_cfg <= 1'b1;
        apb(1'b1, cap_neg_pkg::ctrl_off, 32'h5);
        poll(cap_neg_pkg::st_bad_rep_bit);
        chk(64'(short_grants_only), 64'h1);
        apb(1'b1, cap_neg_pkg::status_off, 32'h10);
        long_cfg <= 1'b0;
        phy_rep[20:11] <= 10'h000;
        pulse(1'b1);
        poll(cap_neg_pkg::st_bad_rep_bit);
        apb(1'b1, cap_neg_pkg::status_off, 32'h10);
        phy_rep[20:11] <= 10'h3ff;
        pulse(1'b1);
        wait_hi(0);
        pulse(1'b0);
        wait_hi(1);
        chk(64'(trace[5:0]), 64'h0b);
        pulse(1'b1);
        poll(cap_neg_pkg::st_unexp_bit);
        tally_and_finish();
    end
endmodule : capability_negotiation_engine_tb_top
